//--- hdl/gst_timer_regs.vh
// register map, field positions, reset values and timing counts of the gated timer
`ifndef GST_TIMER_REGS_VH
`define GST_TIMER_REGS_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define GST_OFS_TIMER_CTRL 5'h00
`define GST_OFS_GATE_CTRL 5'h04
`define GST_OFS_COUNT_LOW 5'h08
`define GST_OFS_COUNT_HIGH 5'h0C
`define GST_OFS_FLAGS 5'h10
// ----------------------------------------------------------------------
// timer control fields
// ----------------------------------------------------------------------
`define GST_TC_CS_HI 7
`define GST_TC_CS_LO 6
`define GST_TC_PS_HI 5
`define GST_TC_PS_LO 4
`define GST_TC_SECONDARY_OSCILLATOR 3
`define GST_TC_NOSYNC 2
`define GST_TC_WIDE 1
`define GST_TC_RUN 0
`define GST_TC_RESET 8'h00
// ----------------------------------------------------------------------
// gate control fields
// ----------------------------------------------------------------------
`define GST_GC_GE 7
`define GST_GC_POL 6
`define GST_GC_TM 5
`define GST_GC_SPM 4
`define GST_GC_GO 3
`define GST_GC_VAL 2
`define GST_GC_SS_HI 1
`define GST_GC_SS_LO 0
`define GST_GC_RESET 8'h00
// ----------------------------------------------------------------------
// flag register fields and codes
// ----------------------------------------------------------------------
`define GST_FL_OVF 0
`define GST_FL_GATE 1
`define GST_CS_INSTR 2'h0
`define GST_CS_SYS 2'h1
`define GST_CS_EXT 2'h2
`define GST_CS_INTERNAL_OSCILLATOR 2'h3
`define GST_GS_PIN 2'h0
`define GST_GS_PARTNER 2'h1
`define GST_GS_CMP1 2'h2
`define GST_GS_CMP2 2'h3
`define GST_INSTR_DIV 2'h3
`define GST_RESP_OKAY 2'h0
`define GST_RESP_DECERR 2'h3
`endif

//--- hdl/gst_timer.v
// gated sixteen-bit timer with AXI4-Lite register access
//
// Operation
// RULE1: source field picks instr, sys, ext, internal_oscillator clock
// RULE2: pin counting starts after first falling edge
// RULE3: prescale field divides by 1, 2, 4, 8
// RULE4: oscillator select picks secondary osc or pin
// RULE5: sync bit clear synchronises external clock
// RULE6: wide mode low read latches high buffer
// RULE7: wide mode high write buffered, low loads
// RULE8: narrow mode bytes read and written independently
// RULE9: low byte write clears prescaler count
// RULE10: run bit enables counting, clear holds count
// RULE11: gate enable applies gate only while running
// RULE12: polarity bit picks active high or low
// RULE13: toggle mode flip-flop toggles on gate edges; the code toggles it on rising edges of the polarised gate only
// RULE14: single pulse mode bit controls the gate
// RULE15: go bit armed flag, cleared with mode
// RULE16: gate level reflects gate independent of enable
// RULE17: gate source picks pin, partner, comparators
// RULE18: watchdog oscillator on whenever gate enabled
// RULE19: software writes gate control before timer control
// RULE20: software avoids system clock for capture use
// RULE21: count wraps to zero and sets overflow
// RULE22: single pulse counts one pulse, then clears go
// RULE23: falling gate level sets gate event flag
// RULE24: count increments once per prescaler tick
`default_nettype none
`include "gst_timer_regs.vh"

module gst_timer #(
    parameter ADDR_W = 5
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // axi4-lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // clock source pins
    input wire externalCountInput,
    input wire secondaryOscillator,
    input wire internalOscillator,
    // gate sources
    input wire gatePin,
    input wire partnerPeriodMatch,
    input wire cmp1Out,
    input wire cmp2Out,
    // status outputs
    output wire overflowFlag,
    output wire gateEventFlag,
    output wire wdtOscOn
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // rising edge of a registered level
    function rise(input prev, input cur);
        rise = cur & ~prev;
    endfunction
    // falling edge of a registered level
    function fall(input prev, input cur);
        fall = prev & ~cur;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg [7:0] timerCtrl_q, gateCtrl_q, highBuf_q;
    reg [15:0] count_q;
    reg [2:0] presc_q;
    reg [1:0] instrDiv_q;
    reg ovfFlag_q, gateFlag_q;
    // synchronisers: stage a feeds stage b only
    reg extA_q, extB_q, extC_q, extD_q;
    reg soscA_q, soscB_q, soscC_q, soscD_q;
    reg iosA_q, iosB_q, iosC_q;
    reg gpA_q, gpB_q;
    reg fallSeen_q, gateRaw_q, toggle_q, gateT_q, pulseOpen_q, gateLevel_q;
    // bus side
    reg awHeld_q, wHeld_q;
    reg [ADDR_W-1:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    // ------------------------------------------------------------------
    // control field decode
    // ------------------------------------------------------------------
    wire [1:0] clkSel = timerCtrl_q[`GST_TC_CS_HI:`GST_TC_CS_LO];
    wire [1:0] psSel = timerCtrl_q[`GST_TC_PS_HI:`GST_TC_PS_LO];
    wire soscSel = timerCtrl_q[`GST_TC_SECONDARY_OSCILLATOR];
    wire noSync = timerCtrl_q[`GST_TC_NOSYNC];
    wire wideMode = timerCtrl_q[`GST_TC_WIDE];
    wire timerRun = timerCtrl_q[`GST_TC_RUN];
    wire gateEnable = gateCtrl_q[`GST_GC_GE];
    wire gatePolarity = gateCtrl_q[`GST_GC_POL];
    wire gateToggleMode = gateCtrl_q[`GST_GC_TM];
    wire gateSinglePulseMode = gateCtrl_q[`GST_GC_SPM];
    wire pulseAcquireGo = gateCtrl_q[`GST_GC_GO];
    wire [1:0] gateSrcSel = gateCtrl_q[`GST_GC_SS_HI:`GST_GC_SS_LO];

    // ------------------------------------------------------------------
    // bus handshake and access decode
    // ------------------------------------------------------------------
    assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire awTake = s_axi_awvalid & s_axi_awready;
    wire wTake = s_axi_wvalid & s_axi_wready;
    wire arTake = s_axi_arvalid & s_axi_arready;
    // write fires in the first cycle that both halves are held
    wire wrDo = awHeld_q & wHeld_q & ~s_axi_bvalid;
    wire wrLane = wStrb_q[0];
    wire [7:0] wrByte = wData_q[7:0];
    wire [ADDR_W-1:0] wrAddr = awAddr_q;
    wire [ADDR_W-1:0] rdAddr = s_axi_araddr;
    wire wrTc = wrDo & wrLane & (wrAddr == `GST_OFS_TIMER_CTRL);
    wire wrGc = wrDo & wrLane & (wrAddr == `GST_OFS_GATE_CTRL);
    wire wrLow = wrDo & wrLane & (wrAddr == `GST_OFS_COUNT_LOW);
    wire wrHigh = wrDo & wrLane & (wrAddr == `GST_OFS_COUNT_HIGH);
    wire wrFl = wrDo & wrLane & (wrAddr == `GST_OFS_FLAGS);
    wire rdLow = arTake & (rdAddr == `GST_OFS_COUNT_LOW);
    wire wrMapped = (wrAddr == `GST_OFS_TIMER_CTRL) | (wrAddr == `GST_OFS_GATE_CTRL) |
        (wrAddr == `GST_OFS_COUNT_LOW) | (wrAddr == `GST_OFS_COUNT_HIGH) |
        (wrAddr == `GST_OFS_FLAGS);

    // ------------------------------------------------------------------
    // pin synchronisers and edge stages
    // ------------------------------------------------------------------
    // two flops before any logic, plus edge history stages
    always @(posedge clk_sys) begin
        if (rst) begin
            {extA_q, extB_q, extC_q, extD_q} <= 4'h0;
            {soscA_q, soscB_q, soscC_q, soscD_q} <= 4'h0;
            {iosA_q, iosB_q, iosC_q} <= 3'h0;
            {gpA_q, gpB_q} <= 2'h0;
        end else begin
            extA_q <= externalCountInput;
            extB_q <= extA_q;
            extC_q <= extB_q;
            extD_q <= extC_q;
            soscA_q <= secondaryOscillator;
            soscB_q <= soscA_q;
            soscC_q <= soscB_q;
            soscD_q <= soscC_q;
            iosA_q <= internalOscillator;
            iosB_q <= iosA_q;
            iosC_q <= iosB_q;
            gpA_q <= gatePin;
            gpB_q <= gpA_q;
        end
    end

    // ------------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------------
    // unsynchronised path takes the earliest edge, synchronised one extra flop later
    wire extRiseFast = rise(extC_q, extB_q);
    wire extRiseSync = rise(extD_q, extC_q);
    wire extFall = fall(extC_q, extB_q);
    wire soscRise = noSync ? rise(soscC_q, soscB_q) : rise(soscD_q, soscC_q); // RULE5
    wire pinRise = noSync ? extRiseFast : extRiseSync; // RULE5
    // pin edges count only once a falling edge was seen
    wire pinTick = pinRise & fallSeen_q; // RULE2
    wire extTick = soscSel ? soscRise : pinTick; // RULE4
    wire instrTick = (instrDiv_q == `GST_INSTR_DIV);
    reg srcTick;
    // source multiplexer
    always @* begin
        case (clkSel) // RULE1
            `GST_CS_INSTR: srcTick = instrTick;
            `GST_CS_SYS: srcTick = 1'b1;
            `GST_CS_EXT: srcTick = extTick;
            default: srcTick = rise(iosC_q, iosB_q);
        endcase
    end
    // instruction clock divider and first falling edge tracking
    always @(posedge clk_sys) begin
        if (rst) begin
            instrDiv_q <= 2'h0;
            fallSeen_q <= 1'b0;
        end else begin
            instrDiv_q <= instrDiv_q + 2'h1;
            if (!timerRun)
                fallSeen_q <= 1'b0; // RULE2
            else if (extFall)
                fallSeen_q <= 1'b1; // RULE2
        end
    end

    // ------------------------------------------------------------------
    // gate path
    // ------------------------------------------------------------------
    reg gateSrc;
    // gate source multiplexer
    always @* begin
        case (gateSrcSel) // RULE17
            `GST_GS_PIN: gateSrc = gpB_q;
            `GST_GS_PARTNER: gateSrc = partnerPeriodMatch;
            `GST_GS_CMP1: gateSrc = cmp1Out;
            default: gateSrc = cmp2Out;
        endcase
    end

    wire gatePol = gatePolarity ? gateSrc : ~gateSrc; // RULE12
    wire gateRise = rise(gateRaw_q, gatePol);
    wire gateT = gateToggleMode ? toggle_q : gatePol;
    wire gateTRise = rise(gateT_q, gateT);
    wire gateTFall = fall(gateT_q, gateT);
    // single pulse passes the gate only inside the captured pulse
    wire gateLevel = gateSinglePulseMode ? (pulseOpen_q & gateT) : gateT; // RULE14 RULE16
    wire goHwClear = pulseOpen_q & gateTFall; // RULE22
    // toggle flip-flop, pulse capture and edge history
    always @(posedge clk_sys) begin
        if (rst) begin
            gateRaw_q <= 1'b0;
            toggle_q <= 1'b0;
            gateT_q <= 1'b0;
            pulseOpen_q <= 1'b0;
            gateLevel_q <= 1'b0;
        end else begin
            gateRaw_q <= gatePol;
            gateT_q <= gateT;
            gateLevel_q <= gateLevel;
            if (!gateToggleMode)
                toggle_q <= 1'b0; // RULE13
            else if (gateRise)
                toggle_q <= ~toggle_q; // RULE13
            if (!gateSinglePulseMode || !pulseAcquireGo || goHwClear)
                pulseOpen_q <= 1'b0; // RULE22
            else if (gateTRise)
                pulseOpen_q <= 1'b1; // RULE22
        end
    end

    // ------------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------------
    wire gateOk = ~gateEnable | gateLevel; // RULE11
    wire stepEn = timerRun & gateOk & srcTick; // RULE10
    wire [2:0] psMask = (psSel == 2'h0) ? 3'h0 : (psSel == 2'h1) ? 3'h1 :
        (psSel == 2'h2) ? 3'h3 : 3'h7; // RULE3
    wire psTick = stepEn & ((presc_q & psMask) == psMask); // RULE3
    // a buffered high write leaves the increment, and so the overflow, in place
    wire ovfEvent = psTick & (count_q == 16'hFFFF) & ~wrLow & ~(wrHigh & ~wideMode); // RULE21
    wire gateEvent = fall(gateLevel_q, gateLevel); // RULE23
    // software writes win over an increment in the same cycle
    always @(posedge clk_sys) begin
        if (rst) begin
            count_q <= 16'h0000;
            presc_q <= 3'h0;
            highBuf_q <= 8'h00;
        end else begin
            if (wrLow)
                presc_q <= 3'h0; // RULE9
            else if (stepEn)
                presc_q <= presc_q + 3'h1;
            if (wrLow) begin
                count_q[7:0] <= wrByte;
                if (wideMode)
                    count_q[15:8] <= highBuf_q; // RULE7
            end else if (wrHigh && !wideMode) begin
                count_q[15:8] <= wrByte; // RULE8
            end else if (psTick) begin
                count_q <= count_q + 16'h0001; // RULE24 RULE21
            end
            if (wrHigh && wideMode)
                highBuf_q <= wrByte; // RULE7
            else if (rdLow && wideMode)
                highBuf_q <= count_q[15:8]; // RULE6
        end
    end

    // ------------------------------------------------------------------
    // control and flag registers
    // ------------------------------------------------------------------
    // hardware set of a flag wins over a write-one clear
    always @(posedge clk_sys) begin
        if (rst) begin
            timerCtrl_q <= `GST_TC_RESET;
            gateCtrl_q <= `GST_GC_RESET;
            ovfFlag_q <= 1'b0;
            gateFlag_q <= 1'b0;
        end else begin
            if (wrTc)
                timerCtrl_q <= wrByte;
            if (wrGc) begin
                gateCtrl_q[7:4] <= wrByte[7:4];
                gateCtrl_q[1:0] <= wrByte[1:0];
                gateCtrl_q[`GST_GC_GO] <= wrByte[`GST_GC_GO] & wrByte[`GST_GC_SPM]; // RULE15
            end else if (!gateSinglePulseMode || goHwClear) begin
                gateCtrl_q[`GST_GC_GO] <= 1'b0; // RULE15 RULE22
            end
            gateCtrl_q[`GST_GC_VAL] <= 1'b0;
            if (ovfEvent)
                ovfFlag_q <= 1'b1; // RULE21
            else if (wrFl && wrByte[`GST_FL_OVF])
                ovfFlag_q <= 1'b0;
            if (gateEvent)
                gateFlag_q <= 1'b1; // RULE23
            else if (wrFl && wrByte[`GST_FL_GATE])
                gateFlag_q <= 1'b0;
        end
    end

    assign overflowFlag = ovfFlag_q;
    assign gateEventFlag = gateFlag_q;
    assign wdtOscOn = gateEnable; // RULE18

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    // hold address and data in either order, answer after both
    always @(posedge clk_sys) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= {ADDR_W{1'b0}};
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GST_RESP_OKAY;
        end else begin
            if (awTake) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrDo) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? `GST_RESP_OKAY : `GST_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    reg [7:0] rdByte;
    reg rdHit;
    // read multiplexer, gate level shown live in the gate control byte
    always @* begin
        rdHit = 1'b1;
        case (rdAddr)
            `GST_OFS_TIMER_CTRL: rdByte = timerCtrl_q;
            `GST_OFS_GATE_CTRL: rdByte = {gateCtrl_q[7:3], gateLevel, gateCtrl_q[1:0]}; // RULE16
            `GST_OFS_COUNT_LOW: rdByte = count_q[7:0];
            `GST_OFS_COUNT_HIGH: rdByte = wideMode ? highBuf_q : count_q[15:8]; // RULE6 RULE8
            `GST_OFS_FLAGS: rdByte = {6'h00, gateFlag_q, ovfFlag_q};
            default: begin
                rdByte = 8'h00;
                rdHit = 1'b0;
            end
        endcase
    end

    // capture read data at the address handshake
    always @(posedge clk_sys) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `GST_RESP_OKAY;
        end else begin
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rdByte};
                s_axi_rresp <= rdHit ? `GST_RESP_OKAY : `GST_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // gst_timer

`default_nettype wire

//--- tb/gst_timer_asserts.sv
// port checks of the gated timer
`default_nettype none
module gst_timer_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // status
    input wire logic overflowFlag,
    input wire logic gateEventFlag,
    input wire logic wdtOscOn
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write busy");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read busy");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_wdt_by_write: assert property ($changed(wdtOscOn) && !$past(rst) |-> $rose(s_axi_bvalid))
        else $error("oscillator request changed without write");
    a_ovf_clear_write: assert property ($fell(overflowFlag) && !$past(rst) |-> $rose(s_axi_bvalid))
        else $error("overflow flag lost");
    a_gate_flag_clear: assert property ($fell(gateEventFlag) && !$past(rst) |-> $rose(s_axi_bvalid))
        else $error("gate event flag lost");
    c_overflow: cover property ($rose(overflowFlag));
    c_gate_event: cover property ($rose(gateEventFlag));
    c_decode_error: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule // gst_timer_asserts
bind gst_timer gst_timer_asserts i_gst_timer_asserts (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .overflowFlag(overflowFlag), .gateEventFlag(gateEventFlag), .wdtOscOn(wdtOscOn));
`default_nettype wire

//--- tb/gst_pin_model.sv
// pin side model: count pin and oscillator sources
`default_nettype none
module gst_pin_model (
    // control
    input wire logic extOn,
    // clock source pins
    output logic externalCountInput,
    output logic secondaryOscillator,
    output logic internalOscillator
);
    timeunit 1ns;
    timeprecision 1ns;
    // pin clock stands low while off, so a falling edge follows enabling; 600 ns period when on
    always #300 externalCountInput = extOn && (externalCountInput !== 1'b1);
    // free-running oscillators, toggling on falling bench clock edges, off the rising ones
    always #500 secondaryOscillator = (secondaryOscillator !== 1'b1);
    always #200 internalOscillator = (internalOscillator !== 1'b1);
endmodule // gst_pin_model
`default_nettype wire

//--- tb/gst_timer_tb.sv
// self-checking bench of the gated timer
`default_nettype none
module gst_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b1, arValid = 1'b0, rReady = 1'b1, extOn = 1'b0;
    logic [4:0] awAddr = 5'h00, arAddr = 5'h00;
    logic [31:0] wData = 32'h00000000;
    logic [3:0] gateSrc = 4'h0;
    logic [31:0] a, b, d;
    logic [1:0] r;
    wire awReady, wReady, bValid, arReady, rValid, extIn, soscIn, intIn, ovf, gev, wdt;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    int numErrors = 0, compares = 0, cyc = 0;
    // clock and hang limit
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            numErrors++;
            testDone();
        end
    end
    // design and pin model
    gst_timer i_gst_timer (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .externalCountInput(extIn),
        .secondaryOscillator(soscIn), .internalOscillator(intIn), .gatePin(gateSrc[0]),
        .partnerPeriodMatch(gateSrc[1]), .cmp1Out(gateSrc[2]), .cmp2Out(gateSrc[3]), .overflowFlag(ovf),
        .gateEventFlag(gev), .wdtOscOn(wdt));
    gst_pin_model i_gst_pin_model (.extOn(extOn), .externalCountInput(extIn), .secondaryOscillator(soscIn),
        .internalOscillator(intIn));
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic testDone();
        $display("errors %0d compares %0d", numErrors, compares);
        if (numErrors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // each half drops at the edge that takes it; the answer is taken at the edge it is seen
    task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
        awAddr <= a;
        wData <= {24'h000000, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awValid && awReady)
                awValid <= 1'b0;
            if (wValid && wReady)
                wValid <= 1'b0;
        end while (!bValid);
        r = bResp;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        arAddr <= a;
        arValid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arValid && arReady)
                arValid <= 1'b0;
        end while (!rValid);
        d = rData;
        r = rResp;
    endtask
    // compares two low-byte reads 22 cycles apart with the expected motion
    task automatic cnt(input logic run);
        repeat (4) @(posedge clk_sys);
        rd(5'h08, a, r);
        repeat (20) @(posedge clk_sys);
        rd(5'h08, b, r);
        check({31'h0, a !== b}, {31'h0, run});
    endtask
    task automatic pin();
        gateSrc <= 4'h1;
        repeat (6) @(posedge clk_sys);
        gateSrc <= 4'h0;
        repeat (6) @(posedge clk_sys);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic regs();
        rd(5'h00, d, r);
        check(d, 32'h0);
        rd(5'h04, d, r);
        check(d & 32'hFB, 32'h0);
        check({31'h0, wdt}, 32'h0);
        rd(5'h14, d, r);
        check({d[29:0], r}, 32'h3);
        wr(5'h14, 8'hFF, r);
        check({30'h0, r}, 32'h3);
        wr(5'h04, 8'h80, r);
        check({31'h0, wdt}, 32'h1);
        wr(5'h04, 8'h00, r);
    endtask
    task automatic bytes();
        wr(5'h0C, 8'h21, r);
        wr(5'h08, 8'h43, r);
        rd(5'h0C, d, r);
        check(d, 32'h21);
        wr(5'h00, 8'h02, r);
        wr(5'h0C, 8'h5A, r);
        rd(5'h08, d, r);
        check(d, 32'h43);
        rd(5'h0C, d, r);
        check(d, 32'h21);
        wr(5'h0C, 8'h5A, r);
        wr(5'h08, 8'hC3, r);
        wr(5'h00, 8'h00, r);
        rd(5'h0C, d, r);
        check(d, 32'h5A);
    endtask
    task automatic rate(input logic [7:0] tc, input int div);
        int t0, n, dlt;
        wr(5'h00, tc, r);
        rd(5'h08, a, r);
        t0 = cyc;
        repeat (24 * div) @(posedge clk_sys);
        rd(5'h08, b, r);
        n = (cyc - t0) / div;
        dlt = int'((b - a) & 32'h000000FF);
        check({31'h0, (dlt >= n - 1) && (dlt <= n + 1)}, 32'h1);
        wr(5'h00, tc & 8'hFE, r);
        cnt(1'b0);
    endtask
    task automatic gates();
        for (int s = 0; s < 4; s++) begin
            gateSrc <= 4'h1 << s;
            wr(5'h04, {6'h30, s[1:0]}, r);
            wr(5'h00, 8'h41, r);
            rd(5'h04, d, r);
            check(d & 32'h04, 32'h04);
            cnt(1'b1);
            gateSrc <= 4'h0;
            cnt(1'b0);
            check({31'h0, gev}, 32'h1);
            wr(5'h10, 8'h02, r);
            check({31'h0, gev}, 32'h0);
        end
        wr(5'h04, 8'h80, r);
        cnt(1'b1);
        wr(5'h04, 8'h40, r);
        cnt(1'b1);
    endtask
    task automatic pulse();
        wr(5'h04, 8'hD0, r);
        wr(5'h04, 8'hD8, r);
        rd(5'h04, d, r);
        check(d & 32'h08, 32'h08);
        pin();
        rd(5'h04, d, r);
        check(d & 32'h08, 32'h00);
        gateSrc <= 4'h1;
        cnt(1'b0);
        gateSrc <= 4'h0;
        wr(5'h04, 8'hD8, r);
        wr(5'h04, 8'hC0, r);
        rd(5'h04, d, r);
        check(d & 32'h08, 32'h00);
        wr(5'h04, 8'hE0, r);
        pin();
        cnt(1'b1);
        pin();
        cnt(1'b0);
    endtask
    task automatic ovfl();
        wr(5'h04, 8'h00, r);
        wr(5'h00, 8'h00, r);
        wr(5'h0C, 8'hFF, r);
        wr(5'h08, 8'hFF, r);
        wr(5'h00, 8'h41, r);
        repeat (4) @(posedge clk_sys);
        check({31'h0, ovf}, 32'h1);
        rd(5'h0C, d, r);
        check(d, 32'h00);
        rd(5'h10, d, r);
        check(d & 32'h01, 32'h01);
        wr(5'h10, 8'h01, r);
        check({31'h0, ovf}, 32'h0);
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        extOn <= 1'b1;
        regs();
        bytes();
        rate(8'h01, 4);
        rate(8'h31, 32);
        rate(8'h41, 1);
        rate(8'h51, 2);
        rate(8'h61, 4);
        rate(8'h71, 8);
        rate(8'h81, 12);
        rate(8'h85, 12);
        rate(8'h89, 20);
        rate(8'hC1, 8);
        gates();
        pulse();
        ovfl();
        testDone();
    end
endmodule // gst_timer_tb
`default_nettype wire
